// [hw/aer_map.svh]
/*
 register offsets, field positions and reset values of the error register tail.
 assumes inclusion by the register bank design file by bare name.
*/
`ifndef AER_MAP_SVH
`define AER_MAP_SVH
`define AER_OFF_SEV 12'h10c
`define AER_OFF_CSTS 12'h110
`define AER_OFF_CMSK 12'h114
`define AER_OFF_CAPC 12'h118
`define AER_OFF_HLOG0 12'h11c
`define AER_OFF_HLOG1 12'h120
`define AER_OFF_HLOG2 12'h124
`define AER_OFF_HLOG3 12'h128
`define AER_OFF_INTS 12'h200
`define AER_OFF_INTM 12'h204
`define AER_OFF_UESTS 12'h208
`define AER_SEV_VALID 32'h001ff011
`define AER_SEV_RESET 32'h00062011
`define AER_COR_VALID 32'h000011c1
`define AER_COR_RESET 32'h00000000
`define AER_INT_VALID 32'h00000003
`define AER_FEP_LSB 0
`define AER_FEP_MSB 4
`define AER_GENCAP_BIT 5
`define AER_GENEN_BIT 6
`define AER_CHKCAP_BIT 7
`define AER_CHKEN_BIT 8
`define AER_INT_COR_BIT 0
`define AER_INT_UNC_BIT 1
`define AER_RESP_OKAY 2'b00
`define AER_RESP_SLVERR 2'b10
`endif

// [hw/aer_pkg.sv]
/*
 types shared by the error register bank, the link model and the bench.
 assumes the map header sits beside it.
*/
package aer_pkg;
   typedef struct packed {
      logic [31:0] unc_evt;
      logic [31:0] cor_evt;
      logic log_valid;
      logic [127:0] hdr;
   } aer_evt_t;
   typedef struct packed {
      logic msg_valid;
      logic msg_fatal;
      logic msg_cor;
      logic gen_ecrc;
      logic chk_ecrc;
   } aer_out_t;
   typedef enum logic [1:0] {
      AER_RD_IDLE = 2'b00,
      AER_RD_WAIT = 2'b01,
      AER_RD_RESP = 2'b10
   } aer_rd_t;
endpackage

// [hw/aer_hdr_log.sv]
/*
 four doubleword header log store with registered read data.
 assumes a single write port from the error logic and one read per cycle.
*/
`timescale 1ns/1ns
`default_nettype none
module aer_hdr_log #(
   parameter int WORDS = 4,
   parameter int AW = 2
) (
   // clock and power-on reset
   input wire logic clk,
   input wire logic rst_n,
   // capture port
   input wire logic wr_en,
   input wire logic [32*WORDS-1:0] wr_data,
   // read port
   input wire logic [AW-1:0] rd_addr,
   output logic [31:0] rd_data
);
   logic [31:0] mem_q [WORDS];
   logic [31:0] mem_d [WORDS];
   logic [31:0] rd_q, rd_d;

   always_comb begin
      for (int i = 0; i < WORDS; i++) begin
         // first doubleword in the top of the capture vector, bytes big endian
         mem_d[i] = wr_en ? wr_data[32*(WORDS-1-i) +: 32] : mem_q[i];
      end
      rd_d = mem_q[rd_addr];
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         for (int i = 0; i < WORDS; i++) begin
            mem_q[i] <= '0;
         end
         rd_q <= '0;
      end else begin
         for (int i = 0; i < WORDS; i++) begin
            mem_q[i] <= mem_d[i];
         end
         rd_q <= rd_d;
      end
   end
   assign rd_data = rd_q;
endmodule
`default_nettype wire

// [hw/aer_regs.sv]
/*
 advanced error reporting tail: severity, correctable status and mask,
 capability and control, header log, plus interrupt status and mask.
 assumes an AXI4-Lite master on MCLK and a power-on reset on RST_N; link
 resets never reach this block, so sticky bits survive them.
*/
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "aer_map.svh"
module aer_regs (
   // clock and power-on reset
   input wire logic MCLK,
   input wire logic RST_N,
   // error events from the link core
   input wire aer_pkg::aer_evt_t EVT,
   input wire logic [31:0] UNC_MASK,
   // controls and error messages toward the root complex
   output aer_pkg::aer_out_t CTRL,
   output logic IRQ,
   // axi4-lite write
   input wire logic [11:0] AWADDR,
   input wire logic AWVALID,
   output logic AWREADY,
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   input wire logic WVALID,
   output logic WREADY,
   output logic [1:0] BRESP,
   output logic BVALID,
   input wire logic BREADY,
   // axi4-lite read
   input wire logic [11:0] ARADDR,
   input wire logic ARVALID,
   output logic ARREADY,
   output logic [31:0] RDATA,
   output logic [1:0] RRESP,
   output logic RVALID,
   input wire logic RREADY
);
   import aer_pkg::*;

   logic [31:0] sev_q, sev_d, csts_q, csts_d, cmsk_q, cmsk_d, uests_q, uests_d;
   logic [31:0] ints_q, ints_d, intm_q, intm_d;
   logic [4:0] fep_q, fep_d;
   logic fep_set_q, fep_set_d, gen_q, gen_d, chk_q, chk_d;
   logic aw_q, aw_d, w_q, w_d, b_q, b_d;
   logic [11:0] awa_q, awa_d, ara_q, ara_d;
   logic [31:0] wd_q, wd_d, wmask, rd_q, rd_d;
   logic [1:0] br_q, br_d, rr_q, rr_d;
   aer_rd_t rs_q, rs_d;
   aer_out_t out_q, out_d;
   logic do_wr, log_en, hit_hlog;
   logic [31:0] log_rd, cor_new, unc_new;
   logic [4:0] first_pos;
   logic [1:0] log_addr;

   assign do_wr = aw_q && w_q && !b_q;
   assign wmask = {{8{WSTRB[3]}}, {8{WSTRB[2]}}, {8{WSTRB[1]}}, {8{WSTRB[0]}}};
   // masked correctable events neither log nor report
   assign cor_new = EVT.cor_evt & `AER_COR_VALID & ~cmsk_q;
   assign unc_new = EVT.unc_evt & `AER_SEV_VALID & ~UNC_MASK;
   assign log_en = EVT.log_valid && ((|cor_new) || (|unc_new));

   always_comb begin
      first_pos = '0;
      for (int i = 20; i >= 0; i--) begin
         if (unc_new[i]) begin
            first_pos = 5'(i);
         end
      end
   end

   // register state: sticky, held over link resets, reset by RST_N only; status bits also clear on a write of one
   always_comb begin
      sev_d = sev_q;
      cmsk_d = cmsk_q;
      gen_d = gen_q;
      chk_d = chk_q;
      intm_d = intm_q;
      csts_d = csts_q;
      ints_d = ints_q;
      uests_d = uests_q;
      fep_d = fep_q;
      fep_set_d = fep_set_q;
      if (do_wr) begin
         unique case (awa_q)
            `AER_OFF_SEV: sev_d = ((sev_q & ~wmask) | (wd_q & wmask)) & `AER_SEV_VALID;
            `AER_OFF_CMSK: cmsk_d = ((cmsk_q & ~wmask) | (wd_q & wmask)) & `AER_COR_VALID;
            `AER_OFF_CAPC: begin
               if (WSTRB[0]) gen_d = wd_q[`AER_GENEN_BIT];
               if (WSTRB[1]) chk_d = wd_q[`AER_CHKEN_BIT];
            end
            `AER_OFF_CSTS: csts_d = csts_q & ~(wd_q & wmask);
            `AER_OFF_INTS: ints_d = ints_q & ~(wd_q & wmask);
            `AER_OFF_INTM: intm_d = ((intm_q & ~wmask) | (wd_q & wmask)) & `AER_INT_VALID;
            `AER_OFF_UESTS: uests_d = uests_q & ~(wd_q & wmask);
            default: ;
         endcase
      end
      // set beats clear in the same cycle
      csts_d = csts_d | (EVT.cor_evt & `AER_COR_VALID);
      uests_d = uests_d | unc_new;
      if (|cor_new) ints_d[`AER_INT_COR_BIT] = 1'b1;
      if (|unc_new) ints_d[`AER_INT_UNC_BIT] = 1'b1;
      // pointer frozen until the uncorrectable status drains
      if (uests_d == '0) fep_set_d = 1'b0;
      if (!fep_set_q && (|unc_new)) begin
         fep_d = first_pos;
         fep_set_d = 1'b1;
      end
   end

   // message toward the root complex, one cycle per event batch
   always_comb begin
      out_d.msg_valid = (|cor_new) || (|unc_new);
      out_d.msg_fatal = |(unc_new & sev_q);
      out_d.msg_cor = |cor_new;
      out_d.gen_ecrc = gen_q;
      out_d.chk_ecrc = chk_q;
   end

   // bus handshake state
   always_comb begin
      aw_d = aw_q;
      w_d = w_q;
      b_d = b_q;
      awa_d = awa_q;
      wd_d = wd_q;
      br_d = br_q;
      if (AWVALID && AWREADY) begin
         aw_d = 1'b1;
         awa_d = {AWADDR[11:2], 2'b00};
      end
      if (WVALID && WREADY) begin
         w_d = 1'b1;
         wd_d = WDATA;
      end
      if (do_wr) begin
         b_d = 1'b1;
         unique case (awa_q)
            `AER_OFF_SEV, `AER_OFF_CSTS, `AER_OFF_CMSK, `AER_OFF_CAPC,
            `AER_OFF_HLOG0, `AER_OFF_HLOG1, `AER_OFF_HLOG2, `AER_OFF_HLOG3,
            `AER_OFF_INTS, `AER_OFF_INTM, `AER_OFF_UESTS: br_d = `AER_RESP_OKAY;
            default: br_d = `AER_RESP_SLVERR;
         endcase
      end
      if (b_q && BREADY) begin
         b_d = 1'b0;
         aw_d = 1'b0;
         w_d = 1'b0;
      end
   end

   assign hit_hlog = (ara_q >= `AER_OFF_HLOG0) && (ara_q <= `AER_OFF_HLOG3);
   // store index off the bus on the take edge, so its register is ready in the wait state
   assign log_addr = (rs_q == AER_RD_IDLE) ? ARADDR[3:2] - 2'b11 : ara_q[3:2] - 2'b11;

   always_comb begin
      rs_d = rs_q;
      ara_d = ara_q;
      rd_d = rd_q;
      rr_d = rr_q;
      unique case (rs_q)
         AER_RD_IDLE: begin
            if (ARVALID) begin
               ara_d = {ARADDR[11:2], 2'b00};
               rs_d = AER_RD_WAIT;
            end
         end
         AER_RD_WAIT: begin
            // log store answers a cycle late, hence the wait state
            rs_d = AER_RD_RESP;
            rr_d = `AER_RESP_OKAY;
            unique case (ara_q)
               `AER_OFF_SEV: rd_d = sev_q;
               `AER_OFF_CSTS: rd_d = csts_q;
               `AER_OFF_CMSK: rd_d = cmsk_q;
               `AER_OFF_CAPC: begin
                  rd_d = '0;
                  rd_d[`AER_FEP_MSB:`AER_FEP_LSB] = fep_q;
                  rd_d[`AER_GENCAP_BIT] = 1'b1;
                  rd_d[`AER_GENEN_BIT] = gen_q;
                  rd_d[`AER_CHKCAP_BIT] = 1'b1;
                  rd_d[`AER_CHKEN_BIT] = chk_q;
               end
               `AER_OFF_INTS: rd_d = ints_q;
               `AER_OFF_INTM: rd_d = intm_q;
               `AER_OFF_UESTS: rd_d = uests_q;
               default: begin
                  rd_d = hit_hlog ? log_rd : '0;
                  rr_d = hit_hlog ? `AER_RESP_OKAY : `AER_RESP_SLVERR;
               end
            endcase
         end
         AER_RD_RESP: begin
            if (RREADY) rs_d = AER_RD_IDLE;
         end
         default: rs_d = AER_RD_IDLE;
      endcase
   end

   aer_hdr_log #(.WORDS(4), .AW(2)) aer_hdr_log_inst (
      .clk(MCLK),
      .rst_n(RST_N),
      .wr_en(log_en),
      .wr_data(EVT.hdr),
      .rd_addr(log_addr),
      .rd_data(log_rd)
   );

   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         sev_q <= `AER_SEV_RESET;
         cmsk_q <= `AER_COR_RESET;
         csts_q <= `AER_COR_RESET;
         uests_q <= '0;
         ints_q <= '0;
         intm_q <= '0;
         fep_q <= '0;
         fep_set_q <= 1'b0;
         gen_q <= 1'b0;
         chk_q <= 1'b0;
         out_q <= '0;
         aw_q <= 1'b0;
         w_q <= 1'b0;
         b_q <= 1'b0;
         awa_q <= '0;
         wd_q <= '0;
         br_q <= '0;
         rs_q <= AER_RD_IDLE;
         ara_q <= '0;
         rd_q <= '0;
         rr_q <= '0;
      end else begin
         sev_q <= sev_d;
         cmsk_q <= cmsk_d;
         csts_q <= csts_d;
         uests_q <= uests_d;
         ints_q <= ints_d;
         intm_q <= intm_d;
         fep_q <= fep_d;
         fep_set_q <= fep_set_d;
         gen_q <= gen_d;
         chk_q <= chk_d;
         out_q <= out_d;
         aw_q <= aw_d;
         w_q <= w_d;
         b_q <= b_d;
         awa_q <= awa_d;
         wd_q <= wd_d;
         br_q <= br_d;
         rs_q <= rs_d;
         ara_q <= ara_d;
         rd_q <= rd_d;
         rr_q <= rr_d;
      end
   end

   assign AWREADY = !aw_q && !b_q;
   assign WREADY = !w_q && !b_q;
   assign BVALID = b_q;
   assign BRESP = br_q;
   assign ARREADY = (rs_q == AER_RD_IDLE);
   assign RVALID = (rs_q == AER_RD_RESP);
   assign RDATA = rd_q;
   assign RRESP = rr_q;
   assign CTRL = out_q;
   assign IRQ = |(ints_q & intm_q);

   rcv_err_a: assert property (@(posedge MCLK) disable iff (!RST_N)
      EVT.cor_evt[0] |=> csts_q[0]) else $error("receiver error not latched");
   bad_pkt_a: assert property (@(posedge MCLK) disable iff (!RST_N)
      EVT.cor_evt[6] && EVT.cor_evt[7] |=> csts_q[7:6] == 2'b11)
      else $error("bad packet bits not set");
   replay_evt_a: assert property (@(posedge MCLK) disable iff (!RST_N)
      EVT.cor_evt[12] |=> csts_q[12])
      else $error("replay timeout not set");
   cor_mask_a: assert property (@(posedge MCLK) disable iff (!RST_N)
      (EVT.cor_evt & cmsk_q) != '0 && (EVT.cor_evt & ~cmsk_q & `AER_COR_VALID) == '0
      && unc_new == '0 |=> !CTRL.msg_valid) else $error("masked error reported");
   first_ptr_a: assert property (@(posedge MCLK) disable iff (!RST_N)
      fep_set_q && uests_q != '0 |=> $stable(fep_q)) else $error("pointer moved");
   cap_bits_a: assert property (@(posedge MCLK) disable iff (!RST_N)
      rs_q == AER_RD_WAIT && ara_q == `AER_OFF_CAPC |=> RDATA[7] && RDATA[5])
      else $error("capability bits not set");
   ecrc_en_a: assert property (@(posedge MCLK) disable iff (!RST_N)
      ##1 CTRL.gen_ecrc == $past(gen_q) && CTRL.chk_ecrc == $past(chk_q))
      else $error("crc enable not followed");
   sev_rsvd_a: assert property (@(posedge MCLK) disable iff (!RST_N)
      (sev_q & ~`AER_SEV_VALID) == '0 && (cmsk_q & ~`AER_COR_VALID) == '0)
      else $error("reserved bits set");
   irq_lvl_a: assert property (@(posedge MCLK) disable iff (!RST_N)
      (|cor_new) && intm_q[`AER_INT_COR_BIT] && !do_wr |=> IRQ)
      else $error("interrupt not raised");
endmodule
`default_nettype wire

// [verif/aer_link_model.sv]
/*
 link core stand-in: pulses error events with a header, counts messages.
 assumes the bench calls fire() right after a rising clock edge.
*/
`timescale 1ns/1ns
`default_nettype none
module aer_link_model (
   // clock
   input wire logic clk,
   // events toward the bank
   output aer_pkg::aer_evt_t evt,
   output logic [31:0] unc_mask,
   // messages back
   input wire aer_pkg::aer_out_t ctrl
);
   import aer_pkg::*;
   int msgs = 0;
   int fatals = 0;
   int cors = 0;
   bit busy = 0;
   initial begin
      evt = '0;
      unc_mask = '0;
   end
   // header lines toggle outside a capture so stale data never looks valid
   always @(posedge clk) begin
      if (!busy) evt.hdr <= ~evt.hdr;
   end
   // counted off the edge: msg_valid is registered
   always @(negedge clk) begin
      if (ctrl.msg_valid) msgs++;
      if (ctrl.msg_valid && ctrl.msg_fatal) fatals++;
      if (ctrl.msg_valid && ctrl.msg_cor) cors++;
   end
   task automatic fire(input logic [31:0] u, input logic [31:0] c, input logic [127:0] h);
      busy = 1;
      @(posedge clk);
      evt <= '{unc_evt: u, cor_evt: c, log_valid: 1'b1, hdr: h};
      @(posedge clk);
      evt.unc_evt <= '0;
      evt.cor_evt <= '0;
      evt.log_valid <= 1'b0;
      repeat (2) @(posedge clk);
      busy = 0;
   endtask
endmodule
`default_nettype wire

// [verif/aer_regs_tb.sv]
/*
 self-checking bench for the error register bank.
 assumes the link model beside it and the design under hw/.
*/
`timescale 1ns/1ns
`default_nettype none
module aer_regs_tb;
   import aer_pkg::*;
   logic mclk, rst_n, irq, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   logic [11:0] awaddr, araddr;
   logic [31:0] unc_mask, wdata, rdata, v;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, r;
   aer_evt_t evt;
   aer_out_t ctrl;
   int bad_count = 0;
   int n_compared = 0;
   int m0;
   aer_regs aer_regs_inst (.MCLK(mclk), .RST_N(rst_n), .EVT(evt), .UNC_MASK(unc_mask),
      .CTRL(ctrl), .IRQ(irq), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
      .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
      .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
      .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready));
   aer_link_model aer_link_model_inst (.clk(mclk), .evt(evt), .unc_mask(unc_mask),
      .ctrl(ctrl));
   initial begin
      mclk = 0;
      forever #2 mclk = ~mclk;
   end
   initial begin
      repeat (20000) @(posedge mclk);
      bad_count++;
      summarize();
   end
   task automatic summarize();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   // handshakes judged at the falling edge: inputs only move at rising edges
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic ha, hw, hb;
      hb = 0;
      @(posedge mclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      while (!hb) begin
         @(negedge mclk);
         ha = awvalid & awready;
         hw = wvalid & wready;
         hb = bvalid;
         r = bresp;
         @(posedge mclk);
         if (ha) awvalid <= 0;
         if (hw) wvalid <= 0;
         if (hb) bready <= 0;
      end
      chk("write resp", 32'h0, {30'h0, r});
   endtask
   task automatic rd(input logic [11:0] a);
      logic ha, hr;
      hr = 0;
      @(posedge mclk);
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
      while (!hr) begin
         @(negedge mclk);
         ha = arvalid & arready;
         hr = rvalid;
         v = rdata;
         r = rresp;
         @(posedge mclk);
         if (ha) arvalid <= 0;
         if (hr) rready <= 0;
      end
   endtask
   task automatic rc(input logic [11:0] a, input logic [31:0] e);
      rd(a);
      chk($sformatf("reg %h", a), e, v);
      chk("read resp", 32'h0, {30'h0, r});
   endtask
   task automatic s_reset();
      rc(12'h10c, 32'h00062011);
      rc(12'h110, 32'h0);
      rc(12'h114, 32'h0);
      rc(12'h118, 32'h000000a0);
      chk("ecrc en", 32'h0, {30'h0, ctrl.gen_ecrc, ctrl.chk_ecrc});
   endtask
   task automatic s_sev();
      wr(12'h10c, 32'hffffffff);
      rc(12'h10c, 32'h001ff011);
      wr(12'h10c, 32'h0);
      rc(12'h10c, 32'h0);
   endtask
   task automatic s_cor();
      int b [5] = '{0, 6, 7, 8, 12};
      logic [31:0] e;
      int c0;
      e = 0;
      m0 = aer_link_model_inst.msgs;
      c0 = aer_link_model_inst.cors;
      foreach (b[i]) begin
         e[b[i]] = 1'b1;
         aer_link_model_inst.fire(32'h0, 32'h1 << b[i], 128'h0);
         rc(12'h110, e);
      end
      chk("messages", 32'd5, aer_link_model_inst.msgs - m0);
      chk("cor msgs", 32'd5, aer_link_model_inst.cors - c0);
      wr(12'h110, 32'h1);
      rc(12'h110, 32'h000011c0);
      wr(12'h110, 32'hffffffff);
      rc(12'h110, 32'h0);
   endtask
   task automatic s_log();
      logic [127:0] h;
      h = 128'h00112233_44556677_8899aabb_ccddeeff;
      aer_link_model_inst.fire(32'h10, 32'h0, h);
      for (int i = 0; i < 4; i++) rc(12'h11c + 12'(4 * i), h[127 - 32 * i -: 32]);
      rc(12'h118, 32'h000000a4);
      aer_link_model_inst.fire(32'h1000, 32'h0, ~h);
      rc(12'h118, 32'h000000a4);
      wr(12'h114, 32'hffffffff);
      rc(12'h114, 32'h000011c1);
      m0 = aer_link_model_inst.msgs;
      aer_link_model_inst.fire(32'h0, 32'h000011c1, {4{32'h5a5a5a5a}});
      chk("masked msgs", 32'h0, aer_link_model_inst.msgs - m0);
      rc(12'h11c, ~h[127:96]);
   endtask
   task automatic s_ctl();
      wr(12'h118, 32'hffffffff);
      rc(12'h118, 32'h000001e4);
      chk("ecrc en", 32'h3, {30'h0, ctrl.gen_ecrc, ctrl.chk_ecrc});
      wr(12'h118, 32'h0);
      rc(12'h118, 32'h000000a4);
      chk("ecrc en", 32'h0, {30'h0, ctrl.gen_ecrc, ctrl.chk_ecrc});
   endtask
   task automatic s_irq();
      wr(12'h114, 32'h0);
      chk("irq idle", 32'h0, {31'h0, irq});
      wr(12'h204, 32'h1);
      chk("irq pending", 32'h1, {31'h0, irq});
      wr(12'h200, 32'h3);
      chk("irq cleared", 32'h0, {31'h0, irq});
      aer_link_model_inst.fire(32'h0, 32'h1, 128'h0);
      chk("irq raised", 32'h1, {31'h0, irq});
      wr(12'h204, 32'h0);
      chk("irq masked", 32'h0, {31'h0, irq});
      rd(12'h300);
      chk("unmapped resp", 32'h2, {30'h0, r});
      rc(12'h208, 32'h00001010);
      wr(12'h208, 32'hffffffff);
      wr(12'h10c, 32'h00040000);
      m0 = aer_link_model_inst.fatals;
      aer_link_model_inst.fire(32'h00040000, 32'h0, 128'h0);
      chk("fatal msgs", 32'd1, aer_link_model_inst.fatals - m0);
      rc(12'h118, 32'h000000b2);
   endtask
   task automatic s_por();
      @(posedge mclk);
      rst_n <= 0;
      repeat (2) @(posedge mclk);
      rst_n <= 1;
      rc(12'h10c, 32'h00062011);
      rc(12'h110, 32'h0);
      rc(12'h118, 32'h000000a0);
   endtask
   initial begin
      rst_n = 0;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      awaddr = 0;
      araddr = 0;
      wdata = 0;
      wstrb = 4'hf;
      repeat (3) @(posedge mclk);
      rst_n <= 1;
      s_reset();
      s_sev();
      s_cor();
      s_log();
      s_ctl();
      s_irq();
      s_por();
      summarize();
   end
endmodule
`default_nettype wire
